// [src/bdm_top.sv]
// banked data memory, status register and register bus slave
//
// Notes on behaviour
// - status bit 5 selects bank 1 for direct accesses, else bank 0.
// - lowest 32 addresses of each bank hold special function registers.
// - static RAM at bank 0 20h-7Fh (20h-6Fh on the 80-byte build); largest build adds bank 1 A0h-BFh.
// - revised builds alias bank 1 F0h-FFh onto bank 0 70h-7Fh.
// - general purpose depth is 80, 96 or 128 bytes per build.
// - every location reachable directly or through the file select pointer.
// - status register may be the destination of any operation.
// - flag-updating writes to status keep the computed zero/carry flags.
// - timeout and powerdown flags ignore instruction writes.
// - clearing status zeroes bits 7:5, sets zero, keeps the rest.
// - subtraction drives carry and digit carry as inverted borrows.
// - timeout set on power-up, watchdog clear, sleep; cleared on time-out.
// - powerdown set on power-up and watchdog clear; cleared by sleep.
// - zero flag set when the result is zero, else cleared.
// - digit carry reflects carry out of the low nibble on addition.
`timescale 1ns/1ns
module bdm_top
   import bdm_pkg::*;
#(
   parameter int GPR_DEPTH = 96,
   parameter bit SHARED_EN = 1'b1
)
(
   input wire logic clock,
   input wire logic resetn,
   // core datapath, one operation per request cycle
   input wire logic core_req,
   input wire bdm_op_type core_op,
   input wire logic core_indirect,
   input wire logic [6:0] core_addr,
   input wire logic [7:0] core_operand,
   input wire logic [2:0] core_bit,
   input wire logic core_to_file,
   input wire logic clear_watchdog_op,
   input wire logic sleep_op,
   input wire logic watchdog_timeout,
   output logic [7:0] core_result,
   output logic [7:0] status_value,
   output logic [7:0] file_select_pointer,
   // register bus
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // bank 0 span: 80 bytes on the smallest build, else the full 96
   localparam int B0_SPAN = (GPR_DEPTH < GPR0_MAX) ? GPR_DEPTH : GPR0_MAX;
   localparam logic [7:0] B0_END = GPR0_LO + 8'(B0_SPAN);
   localparam bit HAS_BANK1 = (GPR_DEPTH > GPR0_MAX);
   localparam bit HAS_SHARED = SHARED_EN && (B0_SPAN == GPR0_MAX);

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] pointer;
      logic [7:0] result;
      logic [7:0] dbg_addr;
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [7:0] wdata;
      logic wlane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } bdm_state_type;

   bdm_state_type state_r;
   bdm_state_type state_nxt;

   // general purpose storage, no reset: contents are unknown at power-up
   logic [7:0] mem [0:GPR_DEPTH-1];

   logic mem_we;
   logic [6:0] mem_idx;
   logic [7:0] mem_wd;

   logic core_via_ptr;
   logic [7:0] core_fa;
   logic core_null;
   logic [7:0] core_map;
   logic [7:0] core_file;
   logic core_gpr_we;
   logic [7:0] dbg_map;
   logic [7:0] dbg_file;

   logic [7:0] alu_res;
   logic alu_zero;
   logic alu_digit;
   logic alu_carry;
   logic alu_touch_zero;
   logic alu_touch_carries;

   // full address to {hit, storage index}; special and missing locations miss
   function automatic logic [7:0] gpr_map(input logic [7:0] fa);
      logic [7:0] r;
      r = 8'h00;
      if (fa >= GPR0_LO && fa < B0_END)
      begin
         r = {1'b1, 7'(fa - GPR0_LO)};
      end
      else if (HAS_BANK1 && fa >= GPR1_LO && fa <= GPR1_HI)
      begin
         r = {1'b1, 7'(fa - GPR1_LO) + GPR1_BASE};
      end
      else if (HAS_SHARED && fa >= SHARED_LO)
      begin
         // both banks land on the same byte, so either view sees every write
         r = {1'b1, 7'(fa - SHARED_LO) + SHARED_BASE};
      end
      return r;
   endfunction : gpr_map

   // value of one location as seen by a read
   function automatic logic [7:0] loc_value(
      input logic [7:0] fa,
      input logic [7:0] map,
      input logic [7:0] gval,
      input logic [7:0] status,
      input logic [7:0] pointer
   );
      logic [7:0] v;
      v = 8'h00;
      if (fa[6:0] == ADDR_STATUS)
      begin
         v = status;
      end
      else if (fa[6:0] == ADDR_POINTER)
      begin
         v = pointer;
      end
      else if (map[7])
      begin
         v = gval;
      end
      return v;
   endfunction : loc_value

   // address resolution: the pointer replaces the direct address when asked
   assign core_via_ptr = core_indirect || (core_addr == ADDR_INDIRECT);
   assign core_fa = core_via_ptr ? state_r.pointer
                    : {state_r.status[BIT_BANK_LOW], core_addr};
   // the indirect slot through itself reads zero and swallows writes
   assign core_null = (core_fa[6:0] == ADDR_INDIRECT);
   assign core_map = gpr_map(core_fa);
   assign core_file = core_null ? 8'h00
                      : loc_value(core_fa, core_map, mem[core_map[6:0]], state_r.status, state_r.pointer);
   assign core_gpr_we = core_req && core_to_file && !core_null && core_map[7];
   assign dbg_map = gpr_map(state_r.dbg_addr);
   assign dbg_file = loc_value(state_r.dbg_addr, dbg_map, mem[dbg_map[6:0]], state_r.status, state_r.pointer);

   bdm_alu u_alu (
      .file_val(core_file),
      .operand(core_operand),
      .op(core_op),
      .bit_sel(core_bit),
      .result(alu_res),
      .zero(alu_zero),
      .digit_carry(alu_digit),
      .carry(alu_carry),
      .touch_zero(alu_touch_zero),
      .touch_carries(alu_touch_carries)
   );

   // next state of the whole block
   always_comb
   begin
      state_nxt = state_r;
      mem_we = 1'b0;
      mem_idx = 7'h00;
      mem_wd = 8'h00;

      // core operation: flags first, then the destination write
      if (core_req)
      begin
         state_nxt.result = alu_res;
         if (alu_touch_zero)
         begin
            state_nxt.status[BIT_ZERO] = alu_zero;
         end
         if (alu_touch_carries)
         begin
            state_nxt.status[BIT_DIGIT_CARRY] = alu_digit;
            state_nxt.status[BIT_CARRY] = alu_carry;
         end
         if (core_to_file && !core_null)
         begin
            if (core_fa[6:0] == ADDR_STATUS)
            begin
               // status is an ordinary destination for the upper bits
               state_nxt.status[7:5] = alu_res[7:5];
               // timeout and powerdown are never taken from the write
               if (!(alu_touch_zero || alu_touch_carries))
               begin
                  state_nxt.status[2:0] = alu_res[2:0];
               end
            end
            else if (core_fa[6:0] == ADDR_POINTER)
            begin
               state_nxt.pointer = alu_res;
            end
            else if (core_map[7])
            begin
               mem_we = 1'b1;
               mem_idx = core_map[6:0];
               mem_wd = alu_res;
            end
         end
      end

      // hardware events; a time-out wins over a same-cycle clear or sleep
      if (clear_watchdog_op)
      begin
         state_nxt.status[BIT_TIMEOUT] = 1'b1;
         state_nxt.status[BIT_POWERDOWN] = 1'b1;
      end
      if (sleep_op)
      begin
         state_nxt.status[BIT_TIMEOUT] = 1'b1;
         state_nxt.status[BIT_POWERDOWN] = 1'b0;
      end
      if (watchdog_timeout)
      begin
         state_nxt.status[BIT_TIMEOUT] = 1'b0;
      end

      // write channel: address and data are taken in either order
      if (s_axi_awvalid && state_r.awready)
      begin
         state_nxt.aw_got = 1'b1;
         state_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_r.wready)
      begin
         state_nxt.w_got = 1'b1;
         state_nxt.wdata = s_axi_wdata[7:0];
         state_nxt.wlane = s_axi_wstrb[0];
      end
      if (state_r.bvalid && s_axi_bready)
      begin
         state_nxt.bvalid = 1'b0;
      end
      // commit waits while the core owns the single storage write port
      if (state_r.aw_got && state_r.w_got && !state_r.bvalid && !core_gpr_we)
      begin
         state_nxt.aw_got = 1'b0;
         state_nxt.w_got = 1'b0;
         state_nxt.bvalid = 1'b1;
         state_nxt.bresp = RESP_OKAY;
         case (state_r.aw_addr[11:2])
            REG_STATUS[11:2], REG_POINTER[11:2]: state_nxt.bresp = RESP_OKAY;
            REG_DBG_ADDR[11:2]:
            begin
               if (state_r.wlane)
               begin
                  state_nxt.dbg_addr = state_r.wdata;
               end
            end
            REG_DBG_DATA[11:2]:
            begin
               // only storage bytes are writable from the bus
               if (state_r.wlane && dbg_map[7])
               begin
                  mem_we = 1'b1;
                  mem_idx = dbg_map[6:0];
                  mem_wd = state_r.wdata;
               end
            end
            default: state_nxt.bresp = RESP_SLVERR;
         endcase
      end
      state_nxt.awready = !state_nxt.aw_got && !state_nxt.bvalid;
      state_nxt.wready = !state_nxt.w_got && !state_nxt.bvalid;

      // read channel: one read under way, answered the cycle after it is taken
      if (state_r.rvalid && s_axi_rready)
      begin
         state_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state_r.arready)
      begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rresp = RESP_OKAY;
         case (s_axi_araddr[11:2])
            REG_STATUS[11:2]: state_nxt.rdata = state_r.status;
            REG_POINTER[11:2]: state_nxt.rdata = state_r.pointer;
            REG_DBG_ADDR[11:2]: state_nxt.rdata = state_r.dbg_addr;
            REG_DBG_DATA[11:2]: state_nxt.rdata = dbg_file;
            default:
            begin
               state_nxt.rdata = 8'h00;
               state_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end
      state_nxt.arready = !state_nxt.rvalid;
   end

   // state register; power-up sets timeout and powerdown
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= '{status: STATUS_RST, pointer: POINTER_RST, dbg_addr: DBG_ADDR_RST,
                      default: '0};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // single write port shared by core and bus
   always_ff @(posedge clock)
   begin
      if (mem_we)
      begin
         mem[mem_idx] <= mem_wd;
      end
   end

   // outputs straight from the state register
   assign core_result = state_r.result;
   assign status_value = state_r.status;
   assign file_select_pointer = state_r.pointer;
   assign s_axi_awready = state_r.awready;
   assign s_axi_wready = state_r.wready;
   assign s_axi_bvalid = state_r.bvalid;
   assign s_axi_bresp = state_r.bresp;
   assign s_axi_arready = state_r.arready;
   assign s_axi_rvalid = state_r.rvalid;
   assign s_axi_rresp = state_r.rresp;
   assign s_axi_rdata = {24'h000000, state_r.rdata};
endmodule : bdm_top

// [src/bdm_pkg.sv]
// constants and types shared by the banked data memory block
package bdm_pkg;
   localparam int DATA_W = 8;
   // special function locations, same in both banks
   localparam logic [6:0] ADDR_INDIRECT = 7'h00;
   localparam logic [6:0] ADDR_STATUS = 7'h03;
   localparam logic [6:0] ADDR_POINTER = 7'h04;
   localparam logic [6:0] SFR_SPAN = 7'h20;
   // general purpose windows in the full 8-bit address space
   localparam logic [7:0] GPR0_LO = 8'h20;
   localparam logic [7:0] GPR1_LO = 8'ha0;
   localparam logic [7:0] GPR1_HI = 8'hbf;
   localparam logic [7:0] SHARED_LO = 8'hf0;
   localparam int GPR0_MAX = 96;
   localparam logic [6:0] GPR1_BASE = 7'h60;
   localparam logic [6:0] SHARED_BASE = 7'h50;
   // status bit positions
   localparam int BIT_CARRY = 0;
   localparam int BIT_DIGIT_CARRY = 1;
   localparam int BIT_ZERO = 2;
   localparam int BIT_POWERDOWN = 3;
   localparam int BIT_TIMEOUT = 4;
   localparam int BIT_BANK_LOW = 5;
   localparam int BIT_BANK_HIGH = 6;
   localparam int BIT_IND_BANK = 7;
   // values after reset
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] POINTER_RST = 8'h00;
   localparam logic [7:0] DBG_ADDR_RST = 8'h00;
   // register bus map, byte addresses
   localparam int AXI_ADDR_W = 12;
   localparam logic [11:0] REG_STATUS = 12'h000;
   localparam logic [11:0] REG_POINTER = 12'h004;
   localparam logic [11:0] REG_DBG_ADDR = 12'h008;
   localparam logic [11:0] REG_DBG_DATA = 12'h00c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // operations of the core datapath
   typedef enum logic [3:0] {
      OP_MOVE_W = 4'h0,
      OP_CLEAR_FILE = 4'h1,
      OP_MOVE_FILE = 4'h2,
      OP_ADD = 4'h3,
      OP_SUBTRACT = 4'h4,
      OP_AND = 4'h5,
      OP_OR = 4'h6,
      OP_XOR = 4'h7,
      OP_NIBBLE_SWAP = 4'h8,
      OP_BIT_CLEAR = 4'h9,
      OP_BIT_SET = 4'ha
   } bdm_op_type;
endpackage : bdm_pkg

// [src/bdm_alu.sv]
// result and flag unit of the core datapath
`timescale 1ns/1ns
module bdm_alu
   import bdm_pkg::*;
(
   input wire logic [7:0] file_val,
   input wire logic [7:0] operand,
   input wire bdm_op_type op,
   input wire logic [2:0] bit_sel,
   output logic [7:0] result,
   output logic zero,
   output logic digit_carry,
   output logic carry,
   output logic touch_zero,
   output logic touch_carries
);
   logic [4:0] low_sum;
   logic [8:0] full_sum;

   // one case per operation; flags follow the result
   always_comb
   begin
      result = file_val;
      touch_zero = 1'b0;
      touch_carries = 1'b0;
      low_sum = '0;
      full_sum = '0;
      case (op)
         OP_MOVE_W: result = operand;
         OP_CLEAR_FILE:
         begin
            result = '0;
            touch_zero = 1'b1;
         end
         OP_MOVE_FILE: touch_zero = 1'b1;
         OP_ADD:
         begin
            low_sum = {1'b0, file_val[3:0]} + {1'b0, operand[3:0]};
            full_sum = {1'b0, file_val} + {1'b0, operand};
            result = full_sum[7:0];
            touch_zero = 1'b1;
            touch_carries = 1'b1;
         end
         OP_SUBTRACT:
         begin
            // two's complement add: carry out is the inverse of borrow
            low_sum = {1'b0, file_val[3:0]} + {1'b0, ~operand[3:0]} + 5'h01;
            full_sum = {1'b0, file_val} + {1'b0, ~operand} + 9'h001;
            result = full_sum[7:0];
            touch_zero = 1'b1;
            touch_carries = 1'b1;
         end
         OP_AND:
         begin
            result = file_val & operand;
            touch_zero = 1'b1;
         end
         OP_OR:
         begin
            result = file_val | operand;
            touch_zero = 1'b1;
         end
         OP_XOR:
         begin
            result = file_val ^ operand;
            touch_zero = 1'b1;
         end
         OP_NIBBLE_SWAP: result = {file_val[3:0], file_val[7:4]};
         OP_BIT_CLEAR: result = file_val & ~(8'h01 << bit_sel);
         OP_BIT_SET: result = file_val | (8'h01 << bit_sel);
         default: result = file_val;
      endcase
      zero = (result == 8'h00);
      digit_carry = low_sum[4];
      carry = full_sum[8];
   end
endmodule : bdm_alu

// [tb/bdm_top_props.sv]
// concurrent checks on the banked data memory ports
`timescale 1ns/1ns
module bdm_top_props
   import bdm_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic core_req,
   input wire bdm_op_type core_op,
   input wire logic core_indirect,
   input wire logic [6:0] core_addr,
   input wire logic [7:0] core_operand,
   input wire logic core_to_file,
   input wire logic clear_watchdog_op,
   input wire logic sleep_op,
   input wire logic watchdog_timeout,
   input wire logic [7:0] core_result,
   input wire logic [7:0] status_value,
   input wire logic [7:0] file_select_pointer,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // no hardware event this cycle, so the flags 4:3 must hold
   wire logic quiet = !clear_watchdog_op && !sleep_op && !watchdog_timeout;
   sequence clear_status_s;
      core_req && core_op == OP_CLEAR_FILE && core_to_file && !core_indirect && core_addr == ADDR_STATUS && quiet;
   endsequence
   sequence flag_op_s;
      core_req && core_op inside {OP_CLEAR_FILE, OP_MOVE_FILE, OP_ADD, OP_SUBTRACT, OP_AND, OP_OR, OP_XOR};
   endsequence
   sequence resp_wait_s;
      s_axi_bvalid;
   endsequence
   reset_values_a: assert property ($rose(resetn) |->
      status_value == STATUS_RST && file_select_pointer == 8'h00)
      else $error("status or pointer wrong after reset");
   timeout_clear_a: assert property (watchdog_timeout |=> !status_value[BIT_TIMEOUT])
      else $error("timeout flag not cleared by time-out");
   sleep_flags_a: assert property (sleep_op && !watchdog_timeout |=> status_value[4:3] == 2'b10)
      else $error("flags wrong after sleep");
   wdt_clear_a: assert property (clear_watchdog_op && !sleep_op && !watchdog_timeout |=>
      status_value[4:3] == 2'b11)
      else $error("flags wrong after watchdog clear");
   hw_bits_only_a: assert property (quiet |=> $stable(status_value[4:3]))
      else $error("timeout or powerdown changed without an event");
   clear_status_a: assert property (clear_status_s |=>
      status_value == {3'b000, $past(status_value[4:3]), 1'b1, $past(status_value[1:0])})
      else $error("clearing status gave a wrong pattern");
   zero_flag_a: assert property (flag_op_s |=> status_value[BIT_ZERO] == (core_result == 8'h00))
      else $error("zero flag disagrees with result");
   sub_borrow_a: assert property (core_req && core_op == OP_SUBTRACT |=> status_value[1:0] ==
      {({1'b0, core_result[3:0]} + {1'b0, $past(core_operand[3:0])}) < 5'h10,
       ({1'b0, core_result} + {1'b0, $past(core_operand)}) < 9'h100})
      else $error("borrow flags wrong after subtract");
   add_carry_a: assert property (core_req && core_op == OP_ADD |=>
      status_value[1:0] == {core_result[3:0] < $past(core_operand[3:0]), core_result < $past(core_operand)})
      else $error("carry flags wrong after add");
   bresp_hold_a: assert property (resp_wait_s |=>
      $past(s_axi_bready) ? !s_axi_bvalid : s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held until bready or not released");
endmodule : bdm_top_props

bind bdm_top bdm_top_props u_props (.clock(clock), .resetn(resetn), .core_req(core_req), .core_op(core_op),
   .core_indirect(core_indirect), .core_addr(core_addr), .core_operand(core_operand), .core_to_file(core_to_file),
   .clear_watchdog_op(clear_watchdog_op), .sleep_op(sleep_op), .watchdog_timeout(watchdog_timeout),
   .core_result(core_result), .status_value(status_value), .file_select_pointer(file_select_pointer),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// [tb/bdm_core_model.sv]
// behavioural core datapath driving operations and hardware events
`timescale 1ns/1ns
module bdm_core_model
   import bdm_pkg::*;
(
   input wire logic clock,
   output logic core_req,
   output bdm_op_type core_op,
   output logic core_indirect,
   output logic [6:0] core_addr,
   output logic [7:0] core_operand,
   output logic [2:0] core_bit,
   output logic core_to_file,
   output logic clear_watchdog_op,
   output logic sleep_op,
   output logic watchdog_timeout
);
   // idle values at time zero
   initial
   begin
      {core_req, core_indirect, core_to_file, clear_watchdog_op, sleep_op, watchdog_timeout} = 6'h00;
      core_op = OP_MOVE_W;
      {core_addr, core_operand, core_bit} = 18'h00000;
   end
   // one operation; hold keeps the request up for a back-to-back follower
   task issue(input bdm_op_type op, input logic ind, input logic [6:0] a, input logic [7:0] v,
      input logic [2:0] b, input logic tf, input logic hold);
      logic [7:0] val;
      val = v;
      // moves into status keep the reserved bank bits clear
      if (a == ADDR_STATUS && op == OP_MOVE_W) val[7:6] = 2'b00;
      // flag-changing ops aimed at status are sent only when a scenario asks
      core_req <= 1'b1;
      core_op <= op;
      core_indirect <= ind;
      core_addr <= a;
      core_operand <= val;
      core_bit <= b;
      core_to_file <= tf;
      @(posedge clock);
      if (!hold)
      begin
         core_req <= 1'b0;
         @(posedge clock);
      end
   endtask : issue
   // one-cycle watchdog and sleep events
   task pulse(input logic cw, input logic sl, input logic wt);
      {clear_watchdog_op, sleep_op, watchdog_timeout} <= {cw, sl, wt};
      @(posedge clock);
      {clear_watchdog_op, sleep_op, watchdog_timeout} <= 3'b000;
      @(posedge clock);
   endtask : pulse
endmodule : bdm_core_model

// [tb/tb_banked_data_memory_status_reg.sv]
// self-checking bench for the banked data memory and status register
`timescale 1ns/1ns
module tb_banked_data_memory_status_reg
   import bdm_pkg::*;
;
   logic clock, resetn, core_req, core_indirect, core_to_file, cw, sl, wt;
   bdm_op_type core_op;
   logic [6:0] core_addr;
   logic [7:0] core_operand, core_result, status_value, file_select_pointer;
   logic [2:0] core_bit;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, r;
   int n_errors, cmp_count;
   typedef struct {bdm_op_type op; logic ind; logic [6:0] a; logic [7:0] v; logic [2:0] b; logic tf;
      logic [7:0] res; logic [7:0] st;} bdm_row_type;
   // op, indirect, address, operand, bit, to file, result, status
   bdm_row_type rows [19] = '{
      '{OP_MOVE_W, 0, 7'h20, 8'h0f, 0, 1, 8'h0f, 8'h18}, '{OP_ADD, 0, 7'h20, 8'h01, 0, 1, 8'h10, 8'h1a},
      '{OP_SUBTRACT, 0, 7'h20, 8'h11, 0, 0, 8'hff, 8'h18}, '{OP_SUBTRACT, 0, 7'h20, 8'h10, 0, 0, 8'h00, 8'h1f},
      '{OP_ADD, 0, 7'h20, 8'hf0, 0, 1, 8'h00, 8'h1d}, '{OP_XOR, 0, 7'h20, 8'h00, 0, 0, 8'h00, 8'h1d},
      '{OP_BIT_SET, 0, 7'h03, 8'h00, 5, 1, 8'h3d, 8'h3d}, '{OP_MOVE_W, 0, 7'h70, 8'ha5, 0, 1, 8'ha5, 8'h3d},
      '{OP_BIT_CLEAR, 0, 7'h03, 8'h00, 5, 1, 8'h1d, 8'h1d}, '{OP_MOVE_FILE, 0, 7'h70, 8'h00, 0, 0, 8'ha5, 8'h19},
      '{OP_CLEAR_FILE, 0, 7'h03, 8'h00, 0, 1, 8'h00, 8'h1d}, '{OP_MOVE_W, 0, 7'h03, 8'hc7, 0, 1, 8'h07, 8'h1f},
      '{OP_ADD, 0, 7'h03, 8'h00, 0, 1, 8'h1f, 8'h18}, '{OP_MOVE_W, 0, 7'h04, 8'h71, 0, 1, 8'h71, 8'h18},
      '{OP_MOVE_W, 1, 7'h00, 8'h3c, 0, 1, 8'h3c, 8'h18}, '{OP_NIBBLE_SWAP, 0, 7'h71, 8'h00, 0, 0, 8'hc3, 8'h18},
      '{OP_AND, 0, 7'h71, 8'h0f, 0, 0, 8'h0c, 8'h18}, '{OP_OR, 0, 7'h71, 8'h00, 0, 0, 8'h3c, 8'h18},
      '{OP_MOVE_FILE, 0, 7'h05, 8'h00, 0, 0, 8'h00, 8'h1c}};
   // event inputs clear, sleep, time-out and the timeout/powerdown pair they leave
   logic [4:0] evs [4] = '{5'b00101, 5'b01010, 5'b10011, 5'b01100};
   bdm_top #(.GPR_DEPTH(96), .SHARED_EN(1'b1)) uut (.clock(clock), .resetn(resetn), .core_req(core_req),
      .core_op(core_op), .core_indirect(core_indirect), .core_addr(core_addr), .core_operand(core_operand),
      .core_bit(core_bit), .core_to_file(core_to_file), .clear_watchdog_op(cw), .sleep_op(sl),
      .watchdog_timeout(wt), .core_result(core_result), .status_value(status_value),
      .file_select_pointer(file_select_pointer), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   bdm_core_model core (.clock(clock), .core_req(core_req), .core_op(core_op), .core_indirect(core_indirect),
      .core_addr(core_addr), .core_operand(core_operand), .core_bit(core_bit), .core_to_file(core_to_file),
      .clear_watchdog_op(cw), .sleep_op(sl), .watchdog_timeout(wt));
   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   task chk_resp(input string name, input logic [1:0] e, input logic [1:0] g);
      chk(name, {30'h0, e}, {30'h0, g});
   endtask : chk_resp
   // bus cycles start at an edge; each channel drops its valid once taken
   task axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
      {awaddr, wdata, wstrb} <= {a, v, 4'hf};
      {awvalid, wvalid, bready} <= 3'b111;
      do
      begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clock);
   endtask : axi_wr
   task axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do
      begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      {v, resp} = {rdata, rresp};
      rready <= 1'b0;
      @(posedge clock);
   endtask : axi_rd
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // free-running 10 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // hang guard, well beyond the roughly 120 cycles the run needs
   initial
   begin
      #500000;
      n_errors++;
      print_verdict();
   end
   initial
   begin
      {resetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = 66'h0;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      chk("status at reset", 8'h18, status_value);
      chk("pointer at reset", 8'h00, file_select_pointer);
      foreach (rows[i])
      begin
         core.issue(rows[i].op, rows[i].ind, rows[i].a, rows[i].v, rows[i].b, rows[i].tf, 1'b0);
         chk("result", rows[i].res, core_result);
         chk("status", rows[i].st, status_value);
      end
      chk("pointer", 8'h71, file_select_pointer);
      // bank switch used by the very next direct write, which lands in unbuilt bank 1 space
      core.issue(OP_MOVE_W, 0, 7'h21, 8'h5a, 0, 1, 0);
      core.issue(OP_BIT_SET, 0, 7'h03, 8'h00, 5, 1, 1);
      core.issue(OP_MOVE_W, 0, 7'h21, 8'h99, 0, 1, 1);
      core.issue(OP_BIT_CLEAR, 0, 7'h03, 8'h00, 5, 1, 0);
      core.issue(OP_MOVE_FILE, 0, 7'h21, 8'h00, 0, 0, 0);
      chk("bank0 byte", 8'h5a, core_result);
      foreach (evs[i])
      begin
         core.pulse(evs[i][4], evs[i][3], evs[i][2]);
         chk("hw flags", evs[i][1:0], status_value[4:3]);
      end
      axi_rd(REG_STATUS, d, r);
      chk("status read", 32'h0, d);
      chk_resp("read okay", RESP_OKAY, r);
      axi_wr(REG_STATUS, 32'hff, r);
      chk_resp("ro write", RESP_OKAY, r);
      axi_rd(REG_STATUS, d, r);
      chk("status kept", 32'h0, d);
      // shared bytes seen through both bank addresses; bank 1 A0h is absent in this build
      foreach (evs[i])
      begin
         axi_wr(REG_DBG_ADDR, {24'h0, i[1] ? 8'ha0 : (i[0] ? 8'hf0 : 8'h70)}, r);
         if (i == 2) axi_wr(REG_DBG_DATA, 32'h55, r);
         axi_rd(REG_DBG_DATA, d, r);
         chk("debug byte", i[1] ? 32'h0 : 32'ha5, d);
      end
      axi_wr(12'h010, 32'h1, r);
      chk_resp("unmapped write", RESP_SLVERR, r);
      axi_rd(12'h010, d, r);
      chk_resp("unmapped read", RESP_SLVERR, r);
      chk("unmapped data", 32'h0, d);
      // second reset in mid-run restores the power-up flags
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      chk("status rereset", 8'h18, status_value);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
      print_verdict();
   end
endmodule : tb_banked_data_memory_status_reg
